// file: iss_pkg.sv
// Shared constants and types for the two-wire slave interface and its bus master
`default_nettype none
package iss_pkg;
  // Register selects on the device's register port
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_MODE = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'hE0;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h81;
  // interface_mode_control fields
  localparam int MODE_SEL_LSB = 5;
  localparam int DEB_LSB = 2;
  localparam int EN_BIT = 1;
  localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
  localparam logic [7:0] MODE_WR_MASK = 8'hEE;
  // bus_status_control fields
  localparam int ST_DONE = 7;
  localparam int ST_HIT = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_TXDIR = 4;
  localparam int ST_ACKSEND = 3;
  localparam int ST_SRW = 2;
  localparam int ST_WAKE = 1;
  localparam int ST_ACKRX = 0;
  // Glitch filter lengths in link clocks, and the SDA delay matching the longest filter
  localparam logic [2:0] DEB_NONE = 3'h0;
  localparam logic [2:0] DEB_SHORT = 3'h2;
  localparam logic [2:0] DEB_LONG = 3'h4;
  localparam int SDA_DLY = 5;
  // Bit counter positions within a byte
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  // Master timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  localparam logic [3:0] HOST_LAST_BIT = 4'h8;
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} iss_cmd_t;
endpackage
`default_nettype wire

// file: iss_link_if.sv
// Two-wire bus carrier joining the slave device and the bus master
`timescale 1ns/1ps
`default_nettype none
interface iss_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // Open-drain wires with pull-up: low whenever any enabled driver drives low
  assign scl = !((!host_scl_oe_n && !host_scl_o) || (!dev_scl_oe_n && !dev_scl_o));
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
  modport host (
    output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
    input scl, sda
  );
  modport dev (
    output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n,
    input scl, sda
  );
endinterface
`default_nettype wire

// file: iss_dev.sv
// Two-wire slave interface: registers, SCL filter and byte engine on the link clock
// Notes on behaviour
// - Mode code 110 selects two-wire slave
// - Filter select: none, two or four clocks
// - Disabled: pins released, engine idle
// - Enable rise resets status flags to reset values, keeps direction
// - Byte done low in transfer, set after eight
// - Address hit set only on matching address
// - Busy set by START, cleared by STOP
// - Direction bit: 0 receive, 1 transmit
// - Ninth clock drives ack_to_send after receive
// - Software clears ack_to_send before next byte
// - Eighth address bit captured as read request
// - Wake-up on match when enabled; software clears
// - Master acknowledge loads ack_received_n; stop on one
// - Address bits 7..1 match, bit 0 free
// - First seven bits MSB first are address
// - Handler inspects flags to find interrupt cause
// - Software sets mode, address, then interrupt enable
// - Data buffer read/write, unknown after reset
// - Address register shares the second-control location
// - Low acknowledge on ninth bit after match
// - Buffer access after match releases SCL
// - START is SDA falling while SCL high
// - Bytes are eight bits, MSB first
`timescale 1ns/1ps
`default_nettype none
module iss_dev (
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [1:0] i_reg_sel,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_irq,
  output logic o_wake,
  iss_link_if.dev link
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_HOLD} iss_state_t;

  logic [7:0] mode_r;
  logic [7:0] addr_r;
  logic [7:0] data_r;
  logic txdir_r;
  logic ack_send_r;
  logic wake_en_r;
  logic done_r;
  logic hit_r;
  logic busy_r;
  logic srw_r;
  logic ack_rx_n_r;
  logic en_q_r;
  logic cap_r;
  logic scl_low_r;
  logic sda_low_r;
  iss_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
  logic [2:0] deb_cnt_r;
  localparam int SDA_DLY_W = iss_pkg::SDA_DLY;
  logic scl_f_r, scl_q_r, sda_q_r;
  logic [SDA_DLY_W-1:0] sda_dly_r;
  // Buffer access taken before the stretch began, so the stretch ends at once
  logic acc_pend_r;

  logic active;
  logic sda_f;
  logic [2:0] deb_need;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic buf_access;
  logic [7:0] tx_src;

  assign active = mode_r[iss_pkg::EN_BIT] &&
                  (mode_r[iss_pkg::MODE_SEL_LSB +: 3] == iss_pkg::MODE_TWO_WIRE);
  assign sda_f = sda_dly_r[SDA_DLY_W-1];
  assign scl_rise = scl_f_r && !scl_q_r;
  assign scl_fall = !scl_f_r && scl_q_r;
  assign start_ev = scl_f_r && scl_q_r && sda_q_r && !sda_f;
  assign stop_ev = scl_f_r && scl_q_r && !sda_q_r && sda_f;
  assign buf_access = (i_reg_wr || i_reg_rd) && (i_reg_sel == iss_pkg::REG_DATA);
  assign tx_src = (i_reg_wr && i_reg_sel == iss_pkg::REG_DATA) ? i_reg_wdata : data_r;

  always_comb begin
    unique case (mode_r[iss_pkg::DEB_LSB +: 2])
      2'h0: deb_need = iss_pkg::DEB_NONE;
      2'h1: deb_need = iss_pkg::DEB_SHORT;
      default: deb_need = iss_pkg::DEB_LONG;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, SCL glitch filter and SDA delay matched to the longest filter setting
  always_ff @(posedge i_link_clk) begin
    if (!i_reset_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_reset_n) begin
      deb_cnt_r <= 3'h0;
      scl_f_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_dly_r <= '1;
    end else begin
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f;
      sda_dly_r <= {sda_dly_r[SDA_DLY_W-2:0], sda_s2_r};
      if (scl_s2_r == scl_f_r) begin
        deb_cnt_r <= 3'h0;
      end else if (deb_cnt_r >= deb_need) begin
        scl_f_r <= scl_s2_r;
        deb_cnt_r <= 3'h0;
      end else begin
        deb_cnt_r <= deb_cnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine and status flags
  always_ff @(posedge i_link_clk) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      done_r <= iss_pkg::STAT_RST[iss_pkg::ST_DONE];
      hit_r <= iss_pkg::STAT_RST[iss_pkg::ST_HIT];
      busy_r <= iss_pkg::STAT_RST[iss_pkg::ST_BUSY];
      srw_r <= iss_pkg::STAT_RST[iss_pkg::ST_SRW];
      ack_rx_n_r <= iss_pkg::STAT_RST[iss_pkg::ST_ACKRX];
      en_q_r <= 1'b0;
      cap_r <= 1'b0;
      acc_pend_r <= 1'b0;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      en_q_r <= active;
      cap_r <= 1'b0;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      if (!active) begin
        state_r <= ST_IDLE;
        acc_pend_r <= 1'b0;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
      end else if (!en_q_r) begin
        done_r <= iss_pkg::STAT_RST[iss_pkg::ST_DONE];
        hit_r <= iss_pkg::STAT_RST[iss_pkg::ST_HIT];
        busy_r <= iss_pkg::STAT_RST[iss_pkg::ST_BUSY];
        srw_r <= iss_pkg::STAT_RST[iss_pkg::ST_SRW];
        ack_rx_n_r <= iss_pkg::STAT_RST[iss_pkg::ST_ACKRX];
      end else if (start_ev) begin
        busy_r <= 1'b1;
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        hit_r <= 1'b0;
        done_r <= 1'b0;
        acc_pend_r <= 1'b0;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
      end else if (stop_ev) begin
        busy_r <= 1'b0;
        state_r <= ST_IDLE;
        acc_pend_r <= 1'b0;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            sda_low_r <= 1'b0;
          end
          ST_HOLD: begin
            if (buf_access || acc_pend_r) begin
              acc_pend_r <= 1'b0;
              scl_low_r <= 1'b0;
              cnt_r <= 4'h0;
              done_r <= 1'b0;
              if (txdir_r) begin
                state_r <= ST_TX;
                tx_sh_r <= tx_src;
                sda_low_r <= !tx_src[7];
              end else begin
                state_r <= ST_RX;
              end
            end
          end
          default: begin
            if (buf_access && done_r) begin
              acc_pend_r <= 1'b1;
              done_r <= 1'b0;
            end
            if (scl_rise) begin
              if (cnt_r < iss_pkg::BIT_ACK) begin
                rx_sh_r <= {rx_sh_r[6:0], sda_f};
              end
              if (cnt_r < iss_pkg::BIT_END) begin
                cnt_r <= cnt_r + 4'h1;
              end
              if (cnt_r == iss_pkg::BIT_LAST) begin
                if (state_r == ST_ADDR) begin
                  if (rx_sh_r[6:0] == addr_r[7:1]) begin
                    hit_r <= 1'b1;
                    done_r <= 1'b1;
                    srw_r <= sda_f;
                    o_irq <= 1'b1;
                    o_wake <= wake_en_r;
                  end else begin
                    state_r <= ST_IDLE;
                  end
                end else begin
                  done_r <= 1'b1;
                  o_irq <= 1'b1;
                  cap_r <= (state_r == ST_RX);
                end
              end
              if (cnt_r == iss_pkg::BIT_ACK && state_r == ST_TX) begin
                ack_rx_n_r <= sda_f;
              end
            end else if (scl_fall) begin
              if (cnt_r == iss_pkg::BIT_ACK) begin
                if (state_r == ST_ADDR) begin
                  sda_low_r <= 1'b1;
                end else if (state_r == ST_RX) begin
                  sda_low_r <= !ack_send_r;
                end else begin
                  sda_low_r <= 1'b0;
                end
              end else if (cnt_r == iss_pkg::BIT_END) begin
                sda_low_r <= 1'b0;
                if (state_r == ST_TX && ack_rx_n_r) begin
                  state_r <= ST_IDLE;
                  acc_pend_r <= 1'b0;
                end else begin
                  state_r <= ST_HOLD;
                  scl_low_r <= 1'b1;
                end
              end else if (state_r == ST_TX && cnt_r != 4'h0) begin
                sda_low_r <= !tx_sh_r[6];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  always_ff @(posedge i_link_clk) begin
    if (!i_reset_n) begin
      mode_r <= iss_pkg::MODE_RST;
      addr_r <= iss_pkg::ADDR_RST;
      txdir_r <= iss_pkg::STAT_RST[iss_pkg::ST_TXDIR];
      ack_send_r <= iss_pkg::STAT_RST[iss_pkg::ST_ACKSEND];
      wake_en_r <= iss_pkg::STAT_RST[iss_pkg::ST_WAKE];
    end else if (i_reg_wr) begin
      unique case (i_reg_sel)
        iss_pkg::REG_DATA: begin
        end
        iss_pkg::REG_ADDR: addr_r <= i_reg_wdata;
        iss_pkg::REG_MODE: mode_r <= i_reg_wdata & iss_pkg::MODE_WR_MASK;
        iss_pkg::REG_STAT: begin
          txdir_r <= i_reg_wdata[iss_pkg::ST_TXDIR];
          ack_send_r <= i_reg_wdata[iss_pkg::ST_ACKSEND];
          wake_en_r <= i_reg_wdata[iss_pkg::ST_WAKE];
        end
      endcase
    end
  end

  // Data buffer has no reset; a received byte wins over a software write
  always_ff @(posedge i_link_clk) begin
    if (cap_r) begin
      data_r <= rx_sh_r;
    end else if (i_reg_wr && i_reg_sel == iss_pkg::REG_DATA) begin
      data_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_sel)
        iss_pkg::REG_DATA: o_reg_rdata <= data_r;
        iss_pkg::REG_ADDR: o_reg_rdata <= addr_r;
        iss_pkg::REG_MODE: o_reg_rdata <= mode_r;
        iss_pkg::REG_STAT: o_reg_rdata <= {done_r, hit_r, busy_r, txdir_r,
                                           ack_send_r, srw_r, wake_en_r, ack_rx_n_r};
      endcase
    end
  end

  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe_n = !scl_low_r;
  assign link.dev_sda_oe_n = !sda_low_r;
endmodule
`default_nettype wire

// file: iss_host.sv
// Two-wire bus master issuing START, byte write, byte read and STOP commands
`timescale 1ns/1ps
`default_nettype none
module iss_host (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire iss_pkg::iss_cmd_t i_cmd,
  input wire logic [7:0] i_wdata,
  input wire logic i_ack_n,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_ack_n,
  iss_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} iss_hstate_t;

  iss_hstate_t state_r;
  logic [7:0] div_r;
  logic [1:0] q_r;
  logic [3:0] bitn_r;
  logic [8:0] tx_sh_r;
  logic [8:0] rx_sh_r;
  logic scl_low_r;
  logic sda_low_r;
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
  logic tick;
  logic step;

  assign tick = (div_r == iss_pkg::QUARTER_LAST);
  // Third quarter waits for SCL really high, so slave clock stretching is honoured
  assign step = tick && (q_r != 2'h2 || scl_s2_r);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit sequencer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= H_IDLE;
      div_r <= 8'h00;
      q_r <= 2'h0;
      bitn_r <= 4'h0;
      tx_sh_r <= 9'h1FF;
      rx_sh_r <= 9'h000;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      o_ready <= 1'b1;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_ack_n <= 1'b1;
    end else begin
      o_done <= 1'b0;
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (state_r == H_IDLE) begin
        div_r <= 8'h00;
        q_r <= 2'h0;
        bitn_r <= 4'h0;
        if (i_cmd_valid) begin
          o_ready <= 1'b0;
          unique case (i_cmd)
            iss_pkg::CMD_START: state_r <= H_START;
            iss_pkg::CMD_WRITE: begin
              state_r <= H_BIT;
              tx_sh_r <= {i_wdata, 1'b1};
            end
            iss_pkg::CMD_READ: begin
              state_r <= H_BIT;
              tx_sh_r <= {8'hFF, i_ack_n};
            end
            iss_pkg::CMD_STOP: state_r <= H_STOP;
          endcase
        end
      end else if (step) begin
        q_r <= q_r + 2'h1;
        unique case (q_r)
          2'h0: begin
            if (state_r == H_START) begin
              sda_low_r <= 1'b0;
            end else if (state_r == H_BIT) begin
              sda_low_r <= !tx_sh_r[8];
            end else begin
              sda_low_r <= 1'b1;
            end
          end
          2'h1: scl_low_r <= 1'b0;
          2'h2: begin
            if (state_r == H_START) begin
              sda_low_r <= 1'b1;
            end else if (state_r == H_BIT) begin
              rx_sh_r <= {rx_sh_r[7:0], sda_s2_r};
            end else begin
              sda_low_r <= 1'b0;
            end
          end
          2'h3: begin
            if (state_r != H_STOP) begin
              scl_low_r <= 1'b1;
            end
            if (state_r == H_BIT && bitn_r != iss_pkg::HOST_LAST_BIT) begin
              bitn_r <= bitn_r + 4'h1;
              tx_sh_r <= {tx_sh_r[7:0], 1'b1};
            end else begin
              state_r <= H_IDLE;
              o_ready <= 1'b1;
              o_done <= 1'b1;
              if (state_r == H_BIT) begin
                o_rdata <= rx_sh_r[8:1];
                o_ack_n <= rx_sh_r[0];
              end
            end
          end
        endcase
      end
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe_n = !scl_low_r;
  assign link.host_sda_oe_n = !sda_low_r;
endmodule
`default_nettype wire

// file: iss_link_monitor.sv
// Concurrent checks on the two-wire bus between the master and the slave
`timescale 1ns/1ps
`default_nettype none
module iss_link_monitor (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r;
  logic sda_r;
  logic [3:0] bit_cnt_r;
  default clocking mon_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    scl_r <= scl;
    sda_r <= sda;
  end
  // SCL rises since the last START, wrapping after the ninth
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bit_cnt_r <= 4'h0;
    end else if (scl && scl_r && sda_r && !sda) begin
      bit_cnt_r <= 4'h0;
    end else if (scl && !scl_r) begin
      bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence idle_s;
    (scl && sda) [*8];
  endsequence
  open_drain_a: assert property (!dev_scl_o && !dev_sda_o && !host_scl_o && !host_sda_o)
    else $error("open-drain output value not low");
  reset_rel_a: assert property (disable iff (1'b0) !i_reset_n [*4] |->
    dev_scl_oe_n && dev_sda_oe_n && host_scl_oe_n && host_sda_oe_n)
    else $error("pins not released in reset");
  start_host_a: assert property (start_s |-> !host_sda_oe_n)
    else $error("START not made by master");
  start_fall_a: assert property (start_s |-> ##[1:400] !scl)
    else $error("SCL not lowered after START");
  stop_host_a: assert property (stop_s |-> $past(!host_sda_oe_n))
    else $error("STOP not made by master");
  stop_idle_a: assert property (stop_s |=> idle_s)
    else $error("bus not idle after STOP");
  dev_sda_hold_a: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("slave moved SDA while SCL high");
  stretch_late_a: assert property ($fell(dev_scl_oe_n) |-> !$past(scl))
    else $error("slave cut an SCL high phase");
  frame_len_a: assert property (stop_s |-> bit_cnt_r == 4'h1)
    else $error("frame not whole nine-bit slots");
endmodule
`default_nettype wire

// file: i2c_slave_serial_interface_test.sv
// Self-checking bench for the two-wire slave against the bus master
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_serial_interface_test;
  typedef struct {logic [8:0] exp; logic [8:0] msk;} iss_note_t;
  localparam iss_pkg::iss_cmd_t C_ST = iss_pkg::CMD_START;
  localparam iss_pkg::iss_cmd_t C_WR = iss_pkg::CMD_WRITE;
  localparam iss_pkg::iss_cmd_t C_RD = iss_pkg::CMD_READ;
  localparam iss_pkg::iss_cmd_t C_SP = iss_pkg::CMD_STOP;
  localparam logic [1:0] R_D = iss_pkg::REG_DATA;
  localparam logic [1:0] R_S = iss_pkg::REG_STAT;
  localparam logic [1:0] R_M = iss_pkg::REG_MODE;
  logic i_clk, link_clk, i_reset_n, reg_wr, reg_rd, irq, wake, cmd_valid, ack_in;
  logic ready, done, ack_out;
  logic rd_pend = 1'b0;
  logic [1:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, wdata, rdata, d1, d2;
  logic [6:0] addr;
  iss_pkg::iss_cmd_t cmd;
  int num_errors = 0;
  int cmp_count = 0;
  int wake_cnt = 0;
  int seed = 86;
  iss_note_t reg_q[$];
  iss_note_t host_q[$];
  iss_note_t hn, rn;
  iss_link_if link ();
  iss_dev iss_dev_i (.i_link_clk(link_clk), .i_reset_n(i_reset_n), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_sel(reg_sel), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .o_irq(irq), .o_wake(wake), .link(link.dev));
  iss_host iss_host_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_wdata(wdata), .i_ack_n(ack_in), .o_ready(ready), .o_done(done),
    .o_rdata(rdata), .o_ack_n(ack_out), .link(link.host));
  iss_link_monitor iss_link_monitor_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .host_scl_o(link.host_scl_o), .host_scl_oe_n(link.host_scl_oe_n),
    .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_scl_o(link.dev_scl_o), .dev_scl_oe_n(link.dev_scl_oe_n),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
    .scl(link.scl), .sda(link.sda));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Compares %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_acc(input logic wr, input logic [1:0] sel, input logic [7:0] d,
                         input logic [7:0] m);
    if (!wr) reg_q.push_back('{{1'b0, d}, {1'b0, m}});
    @(posedge link_clk);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_sel = sel;
    reg_wdata = d;
    @(posedge link_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic sw_wr(input logic [1:0] sel, input logic [7:0] d);
    reg_acc(1'b1, sel, d, 8'h00);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (irq !== 1'b1 && n < 20000);
    if (n >= 20000) num_errors++;
  endtask
  task automatic host_cmd(input iss_pkg::iss_cmd_t c, input logic [7:0] d, input logic a,
                          input logic [8:0] e, input logic [8:0] m);
    int n;
    n = 0;
    host_q.push_back('{e, m});
    @(posedge i_clk);
    while (ready !== 1'b1) @(posedge i_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = c;
    wdata = d;
    ack_in = a;
    @(posedge i_clk);
    #1;
    cmd_valid = 1'b0;
    do begin
      @(posedge i_clk);
      n++;
    end while (done !== 1'b1 && n < 60000);
    if (n >= 60000) num_errors++;
  endtask
  task automatic bus(input iss_pkg::iss_cmd_t c);
    host_cmd(c, 8'h00, 1'b1, 9'h000, 9'h000);
  endtask
  task automatic xfer(input iss_pkg::iss_cmd_t c, input logic [7:0] d, input logic a,
                      input logic [8:0] e, input logic w);
    fork
      host_cmd(c, d, a, e, 9'h1FF);
      if (w) wait_irq();
    join
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchers take the oldest note whenever a result shows
  always @(posedge i_clk) begin
    if (done === 1'b1) begin
      hn = host_q.pop_front();
      check("bus byte", {ack_out, rdata} & hn.msk, hn.exp & hn.msk);
    end
  end
  always @(posedge link_clk) begin
    if (rd_pend) begin
      rn = reg_q.pop_front();
      check("register", {1'b0, reg_rdata} & rn.msk, rn.exp & rn.msk);
    end
    rd_pend <= reg_rd;
    if (wake === 1'b1) wake_cnt++;
  end
  initial begin
    // About 75k clocks of traffic expected; the 95k-clock limit leaves margin
    #1900000;
    num_errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 8'h00;
    cmd_valid = 1'b0;
    cmd = C_ST;
    wdata = 8'h00;
    ack_in = 1'b1;
    addr = 7'($random(seed));
    repeat (10) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    reg_acc(1'b0, R_M, 8'hE0, 8'hFF);
    reg_acc(1'b0, iss_pkg::REG_ADDR, 8'h00, 8'hFE);
    reg_acc(1'b0, R_S, 8'h81, 8'hFF);
    sw_wr(iss_pkg::REG_ADDR, {addr, 1'b1});
    reg_acc(1'b0, iss_pkg::REG_ADDR, {addr, 1'b1}, 8'hFF);
    for (int deb = 0; deb < 3; deb++) begin
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      sw_wr(R_M, {3'h6, 1'b0, 2'(deb), 2'h2});
      reg_acc(1'b0, R_M, {3'h6, 1'b0, 2'(deb), 2'h2}, 8'hFF);
      if (deb == 0) sw_wr(R_S, 8'h02);
      bus(C_ST);
      reg_acc(1'b0, R_S, 8'h20, 8'h20);
      xfer(C_WR, {addr, 1'b0}, 1'b1, {1'b0, addr, 1'b0}, 1'b1);
      reg_acc(1'b0, R_S, 8'hE0, 8'hF4);
      reg_acc(1'b0, R_D, 8'h00, 8'h00);
      reg_acc(1'b0, R_S, 8'h00, 8'h80);
      xfer(C_WR, d1, 1'b1, {1'b0, d1}, 1'b1);
      reg_acc(1'b0, R_D, d1, 8'hFF);
      sw_wr(R_S, 8'h08);
      xfer(C_WR, d2, 1'b1, {1'b1, d2}, 1'b1);
      reg_acc(1'b0, R_D, d2, 8'hFF);
      sw_wr(R_S, 8'h00);
      bus(C_SP);
      reg_acc(1'b0, R_S, 8'h00, 8'h20);
    end
    bus(C_ST);
    xfer(C_WR, {addr, 1'b1}, 1'b1, {1'b0, addr, 1'b1}, 1'b1);
    reg_acc(1'b0, R_S, 8'hE4, 8'hE4);
    sw_wr(R_S, 8'h10);
    sw_wr(R_D, d1);
    xfer(C_RD, 8'h00, 1'b0, {1'b0, d1}, 1'b1);
    reg_acc(1'b0, R_S, 8'h00, 8'h01);
    sw_wr(R_D, d2);
    xfer(C_RD, 8'h00, 1'b1, {1'b1, d2}, 1'b0);
    reg_acc(1'b0, R_S, 8'h01, 8'h01);
    bus(C_SP);
    sw_wr(R_S, 8'h18);
    sw_wr(R_M, 8'hC0);
    sw_wr(R_M, 8'hC2);
    reg_acc(1'b0, R_S, 8'h99, 8'hFF);
    sw_wr(R_S, 8'h00);
    sw_wr(R_M, 8'hC0);
    bus(C_ST);
    xfer(C_WR, {addr, 1'b0}, 1'b1, {1'b1, addr, 1'b0}, 1'b0);
    bus(C_SP);
    sw_wr(R_M, 8'hA2);
    bus(C_ST);
    xfer(C_WR, {addr, 1'b0}, 1'b1, {1'b1, addr, 1'b0}, 1'b0);
    bus(C_SP);
    sw_wr(R_M, 8'hC2);
    bus(C_ST);
    xfer(C_WR, {~addr[6], addr[5:0], 1'b0}, 1'b1, {1'b1, ~addr[6], addr[5:0], 1'b0}, 1'b0);
    bus(C_SP);
    reg_acc(1'b0, R_S, 8'h00, 8'h40);
    repeat (4) @(posedge link_clk);
    check("wake count", 9'(wake_cnt), 9'h001);
    end_sim();
  end
endmodule
`default_nettype wire
